// file: logic/alu_status_core.sv
// Chosen here: the address-and-strobe port.
`timescale 1ns/100ps
// Operation
// RULE1: operands are working register and file/immediate
// RULE2: status register accepts any instruction write
// RULE3: flag-updating writes keep ALU flags instead
// RULE4: clear of status gives 0000u1uu
// RULE5: software prefers bit, swap, move writes
// RULE6: subtraction carry and digit carry are borrows
// RULE7: overflow beyond +127 or -128 sets flag
// RULE8: status holds flags and pointer mode bits
// RULE9: product low byte readable at 18h
// RULE10: product high byte readable at 19h
// RULE11: mode 00 decrements, 01 increments, 1x holds
// RULE12: overflow flag sits in bit 3
// RULE13: carry from msb, rotates load source bit
// RULE14: zero in bit 2, digit carry bit 1
// RULE15: pointer1 mode bits 7-6, pointer0 bits 5-4
module alu_status_core
    import alu_status_pkg::*;
(
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic exec_valid,
    input wire alu_op_t exec_op,
    input wire src_sel_t exec_src,
    input wire logic [7:0] exec_imm,
    input wire logic [7:0] exec_file_data,
    input wire logic [2:0] exec_bit,
    input wire logic exec_to_file,
    input wire logic [7:0] exec_file_addr,
    input wire logic ptr0_access,
    input wire logic ptr1_access,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    output logic [7:0] result_ff,
    output logic result_valid_ff,
    output logic [7:0] file_addr_ff,
    output logic [7:0] working_ff_out,
    output logic [7:0] alu_status_out,
    output logic [7:0] pointer0_out,
    output logic [7:0] pointer1_out
);
    typedef struct packed {
        logic [7:0] working_ff;
        logic [7:0] status_ff;
        logic [7:0] ptr0_ff;
        logic [7:0] ptr1_ff;
        logic [7:0] result_ff;
        logic res_valid_ff;
        logic [7:0] faddr_ff;
        logic [7:0] rdata_ff;
        logic rd_prod_ff;
    } core_t;
    core_t st_ff;
    core_t nxt_st;

    // ==========================================================
    // helpers
    // pointer step per two-bit mode field
    function automatic logic [7:0] step_ptr(input logic [7:0] p, input logic [1:0] m);
        // RULE11: mode encodings
        case (m)
            MODE_DEC: step_ptr = p - ONE_BYTE;
            MODE_INC: step_ptr = p + ONE_BYTE;
            default: step_ptr = p;
        endcase
    endfunction : step_ptr

    function automatic logic is_product(input logic [7:0] a);
        is_product = (a == PRODUCT_LOW_ADDR) || (a == PRODUCT_HIGH_ADDR);
    endfunction : is_product

    // ==========================================================
    // datapath signals
    logic [7:0] opa;
    logic [7:0] opb;
    logic [8:0] sum9;
    logic [4:0] sum5;
    logic [7:0] res;
    logic [15:0] prod;
    logic upd_c;
    logic upd_dc;
    logic upd_z;
    logic upd_ov;
    logic new_c;
    logic new_dc;
    logic new_ov;
    logic mul_en;
    logic prod_wr;
    logic [7:0] prod_rd;
    logic [7:0] addb;
    logic cin;

    // operand selection and arithmetic
    always_comb begin
        opa = st_ff.working_ff;
        // RULE1: operand b source
        opb = (exec_src == SRC_IMM) ? exec_imm : exec_file_data;
        // RULE6: subtract adds complement
        addb = opb;
        cin = 1'b0;
        res = opb;
        upd_c = 1'b0;
        upd_dc = 1'b0;
        upd_z = 1'b0;
        upd_ov = 1'b0;
        new_c = st_ff.status_ff[CARRY_BIT];
        case (exec_op)
            OP_SUB: begin
                addb = opb;
                opa = ~st_ff.working_ff;
                cin = 1'b1; // f - w = f + ~w + 1
            end
            OP_INC: begin
                opa = ZERO_BYTE;
                cin = 1'b1;
            end
            OP_DEC: begin
                opa = 8'hFF;
            end
            default: begin
                opa = st_ff.working_ff;
            end
        endcase
        sum9 = {1'b0, opa} + {1'b0, addb} + {8'h00, cin};
        sum5 = {1'b0, opa[3:0]} + {1'b0, addb[3:0]} + {4'h0, cin};
        // RULE7: signed overflow
        new_ov = (opa[7] == addb[7]) && (sum9[7] != opa[7]);
        // RULE13: carry from msb
        new_c = sum9[8];
        // RULE14: digit carry
        new_dc = sum5[4];
        prod = opa * opb;
        case (exec_op)
            OP_ADD, OP_SUB, OP_INC, OP_DEC: begin
                res = sum9[7:0];
                upd_c = 1'b1;
                upd_dc = 1'b1;
                upd_z = 1'b1;
                upd_ov = 1'b1;
            end
            OP_AND: begin
                res = st_ff.working_ff & opb;
                upd_z = 1'b1;
            end
            OP_IOR: begin
                res = st_ff.working_ff | opb;
                upd_z = 1'b1;
            end
            OP_XOR: begin
                res = st_ff.working_ff ^ opb;
                upd_z = 1'b1;
            end
            OP_CLR: begin
                res = ZERO_BYTE;
                upd_z = 1'b1;
            end
            OP_RRC: begin
                // RULE13: rotate loads low bit
                res = {st_ff.status_ff[CARRY_BIT], opb[7:1]};
                new_c = opb[0];
                upd_c = 1'b1;
            end
            OP_RLC: begin
                // RULE13: rotate loads high bit
                res = {opb[6:0], st_ff.status_ff[CARRY_BIT]};
                new_c = opb[7];
                upd_c = 1'b1;
            end
            OP_SWAP: res = {opb[3:0], opb[7:4]};
            OP_BCF: res = opb & ~(ONE_BYTE << exec_bit);
            OP_BSF: res = opb | (ONE_BYTE << exec_bit);
            OP_MUL: res = opb;
            default: res = opb;
        endcase
    end

    assign mul_en = exec_valid && (exec_op == OP_MUL);
    assign prod_wr = reg_wr && is_product(reg_addr);

    // ==========================================================
    // state update
    always_comb begin
        nxt_st = st_ff;
        nxt_st.res_valid_ff = 1'b0;
        nxt_st.rd_prod_ff = reg_rd && is_product(reg_addr);
        // pointer post-access stepping
        if (ptr0_access) begin
            // RULE15: pointer0 mode bits
            nxt_st.ptr0_ff = step_ptr(st_ff.ptr0_ff, st_ff.status_ff[P0_MODE_LO +: 2]);
        end
        if (ptr1_access) begin
            nxt_st.ptr1_ff = step_ptr(st_ff.ptr1_ff, st_ff.status_ff[P1_MODE_LO +: 2]);
        end
        // plain software register writes
        if (reg_wr) begin
            case (reg_addr)
                ALU_STATUS_ADDR: nxt_st.status_ff = reg_wdata;
                WORKING_ADDR: nxt_st.working_ff = reg_wdata;
                POINTER0_ADDR: nxt_st.ptr0_ff = reg_wdata;
                POINTER1_ADDR: nxt_st.ptr1_ff = reg_wdata;
                default: nxt_st.working_ff = st_ff.working_ff;
            endcase
        end
        if (exec_valid && exec_op != OP_NONE && exec_op != OP_MUL) begin
            nxt_st.result_ff = res;
            nxt_st.res_valid_ff = exec_to_file;
            nxt_st.faddr_ff = exec_file_addr;
            if (!exec_to_file) begin
                nxt_st.working_ff = res;
            end else if (exec_file_addr == ALU_STATUS_ADDR) begin
                // RULE2: status as destination
                // RULE8: mode bits taken from result
                nxt_st.status_ff = res;
                // RULE3: flag bits come from alu
                // RULE4: clear gives 0000u1uu
                // a flag-updating op blocks the write of all four flag bits;
                // untouched flags keep their old value, the rest follow below
                if (upd_c || upd_dc || upd_z || upd_ov) begin
                    nxt_st.status_ff[OVERFLOW_BIT:CARRY_BIT] =
                        st_ff.status_ff[OVERFLOW_BIT:CARRY_BIT];
                end
            end
            // RULE12: overflow in bit 3
            if (upd_ov) nxt_st.status_ff[OVERFLOW_BIT] = new_ov;
            // RULE14: zero flag
            if (upd_z) nxt_st.status_ff[ZERO_BIT] = (res == ZERO_BYTE);
            if (upd_dc) nxt_st.status_ff[DIGIT_CARRY_BIT] = new_dc;
            if (upd_c) nxt_st.status_ff[CARRY_BIT] = new_c;
        end
        // register read port
        case (reg_addr)
            ALU_STATUS_ADDR: nxt_st.rdata_ff = st_ff.status_ff;
            WORKING_ADDR: nxt_st.rdata_ff = st_ff.working_ff;
            POINTER0_ADDR: nxt_st.rdata_ff = st_ff.ptr0_ff;
            POINTER1_ADDR: nxt_st.rdata_ff = st_ff.ptr1_ff;
            default: nxt_st.rdata_ff = ZERO_BYTE;
        endcase
        if (!reg_rd) nxt_st.rdata_ff = ZERO_BYTE;
        if (!reset_n) begin
            nxt_st = '0;
            nxt_st.status_ff = ALU_STATUS_RESET;
        end
    end

    always_ff @(posedge core_clk) begin
        st_ff <= nxt_st;
    end

    // ==========================================================
    // product store
    // RULE9: low byte at 18h
    // RULE10: high byte at 19h
    product_store u_prod (
        .core_clk(core_clk),
        .wr_en(prod_wr),
        .wr_sel(reg_addr == PRODUCT_HIGH_ADDR),
        .wr_data(reg_wdata),
        .mul_en(mul_en),
        .mul_data(prod),
        .rd_sel(reg_addr == PRODUCT_HIGH_ADDR),
        .rd_data_ff(prod_rd)
    );

    assign reg_rdata = st_ff.rd_prod_ff ? prod_rd : st_ff.rdata_ff;
    assign result_ff = st_ff.result_ff;
    assign result_valid_ff = st_ff.res_valid_ff;
    assign file_addr_ff = st_ff.faddr_ff;
    assign working_ff_out = st_ff.working_ff;
    assign alu_status_out = st_ff.status_ff;
    assign pointer0_out = st_ff.ptr0_ff;
    assign pointer1_out = st_ff.ptr1_ff;
endmodule : alu_status_core

// file: logic/alu_status_pkg.sv
package alu_status_pkg;
    // ==========================================================
    // register offsets
    localparam logic [7:0] ALU_STATUS_ADDR = 8'h04;
    localparam logic [7:0] PRODUCT_LOW_ADDR = 8'h18;
    localparam logic [7:0] PRODUCT_HIGH_ADDR = 8'h19;
    localparam logic [7:0] WORKING_ADDR = 8'h0A;
    localparam logic [7:0] POINTER0_ADDR = 8'h01;
    localparam logic [7:0] POINTER1_ADDR = 8'h09;
    // ==========================================================
    // status field positions
    localparam int CARRY_BIT = 0;
    localparam int DIGIT_CARRY_BIT = 1;
    localparam int ZERO_BIT = 2;
    localparam int OVERFLOW_BIT = 3;
    localparam int P0_MODE_LO = 4;
    localparam int P1_MODE_LO = 6;
    localparam logic [7:0] ALU_STATUS_RESET = 8'hF0;
    localparam logic [7:0] FLAG_MASK = 8'h0F;
    localparam logic [7:0] ZERO_BYTE = 8'h00;
    localparam logic [7:0] ONE_BYTE = 8'h01;
    // ==========================================================
    // pointer mode encodings
    localparam logic [1:0] MODE_DEC = 2'h0;
    localparam logic [1:0] MODE_INC = 2'h1;
    // ==========================================================
    // operations
    typedef enum logic [3:0] {
        OP_NONE, OP_ADD, OP_SUB, OP_AND, OP_IOR, OP_XOR, OP_MOV, OP_CLR,
        OP_INC, OP_DEC, OP_RRC, OP_RLC, OP_SWAP, OP_BCF, OP_BSF, OP_MUL
    } alu_op_t;
    // operand b source
    typedef enum logic {
        SRC_FILE, SRC_IMM
    } src_sel_t;
endpackage : alu_status_pkg

// file: logic/product_store.sv
`timescale 1ns/100ps
// two-byte product store, registered read port, no reset (keeps value)
module product_store
    import alu_status_pkg::*;
(
    input wire logic core_clk,
    input wire logic wr_en,
    input wire logic wr_sel,
    input wire logic [7:0] wr_data,
    input wire logic mul_en,
    input wire logic [15:0] mul_data,
    input wire logic rd_sel,
    output logic [7:0] rd_data_ff
);
    typedef struct packed {
        logic [7:0] low_ff;
        logic [7:0] high_ff;
        logic [7:0] rd_ff;
    } store_t;
    store_t st_ff;
    store_t nxt_st;

    // ==========================================================
    // next state
    always_comb begin
        nxt_st = st_ff;
        if (mul_en) begin
            nxt_st.low_ff = mul_data[7:0];
            nxt_st.high_ff = mul_data[15:8];
        end else if (wr_en) begin
            if (wr_sel) begin
                nxt_st.high_ff = wr_data;
            end else begin
                nxt_st.low_ff = wr_data;
            end
        end
        nxt_st.rd_ff = rd_sel ? st_ff.high_ff : st_ff.low_ff;
    end

    // registers, untouched by any reset
    always_ff @(posedge core_clk) begin
        st_ff <= nxt_st;
    end

    assign rd_data_ff = st_ff.rd_ff;
endmodule : product_store

// file: bench/core_model.sv
`timescale 1ns/100ps
// =====================================
// instruction issue side of the core
module core_model
    import alu_status_pkg::*;
(
    input wire logic core_clk,
    output logic exec_valid,
    output alu_op_t exec_op,
    output src_sel_t exec_src,
    output logic [7:0] exec_imm,
    output logic [7:0] exec_file_data,
    output logic [2:0] exec_bit,
    output logic exec_to_file,
    output logic [7:0] exec_file_addr,
    output logic ptr0_access,
    output logic ptr1_access
);
    // idle state, unused operand lines carry junk
    initial begin
        exec_valid = 0;
        exec_op = OP_NONE;
        exec_src = SRC_FILE;
        {exec_imm, exec_file_data, exec_bit} = 19'h5A5A5;
        {exec_to_file, exec_file_addr, ptr0_access, ptr1_access} = 11'h0;
    end
    // status altered by bit or move ops except lockout checks
    // one instruction, unused operand source gets the inverse value
    task issue(alu_op_t op, src_sel_t src, logic [7:0] b, logic [2:0] bt, logic tf,
               logic [7:0] fa);
        exec_valid <= 1;
        exec_op <= op;
        exec_src <= src;
        exec_imm <= (src == SRC_IMM) ? b : ~b;
        exec_file_data <= (src == SRC_IMM) ? ~b : b;
        exec_bit <= bt;
        exec_to_file <= tf;
        exec_file_addr <= fa;
        @(posedge core_clk);
        exec_valid <= 0;
        exec_op <= OP_NONE;
    endtask : issue
    // indirect access pulses
    task step(logic p0, logic p1);
        ptr0_access <= p0;
        ptr1_access <= p1;
        @(posedge core_clk);
        {ptr0_access, ptr1_access} <= 2'h0;
    endtask : step
endmodule : core_model

// file: bench/alu_status_assertions.sv
`timescale 1ns/100ps
// =====================================
// port checker of the status core
module alu_status_checker
    import alu_status_pkg::*;
(
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic exec_valid,
    input wire alu_op_t exec_op,
    input wire src_sel_t exec_src,
    input wire logic [7:0] exec_imm,
    input wire logic [7:0] exec_file_data,
    input wire logic [2:0] exec_bit,
    input wire logic exec_to_file,
    input wire logic [7:0] exec_file_addr,
    input wire logic ptr0_access,
    input wire logic ptr1_access,
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic [7:0] working_ff_out,
    input wire logic [7:0] alu_status_out,
    input wire logic [7:0] pointer0_out,
    input wire logic [7:0] pointer1_out
);
    logic [7:0] opb, w, st, bsf_res, step0, step1, prod_lo;
    logic [8:0] sum;
    logic [1:0] nobor;
    logic ovf;
    // expected flags and steps
    always_comb begin
        w = working_ff_out;
        st = alu_status_out;
        opb = (exec_src == SRC_IMM) ? exec_imm : exec_file_data;
        sum = {1'b0, w} + {1'b0, opb};
        ovf = (w[7] == opb[7]) && (sum[7] != opb[7]);
        nobor = {opb[3:0] >= w[3:0], opb >= w};
        bsf_res = exec_file_data | (ONE_BYTE << exec_bit);
        step0 = st[5] ? 8'h00 : (st[4] ? 8'h01 : 8'hFF);
        step1 = st[7] ? 8'h00 : (st[6] ? 8'h01 : 8'hFF);
        prod_lo = 8'(w * opb);
    end
    default clocking @(posedge core_clk); endclocking
    default disable iff (!reset_n);
    sequence add_w; exec_valid && exec_op == OP_ADD && !exec_to_file && !reg_wr; endsequence
    sequence sub_w; exec_valid && exec_op == OP_SUB && !exec_to_file && !reg_wr; endsequence
    sequence to_st(alu_op_t op);
        exec_valid && exec_op == op && exec_to_file && exec_file_addr == ALU_STATUS_ADDR && !reg_wr;
    endsequence
    sequence mul_rd;
        exec_valid && exec_op == OP_MUL && !reg_wr ##1 reg_rd && reg_addr == PRODUCT_LOW_ADDR;
    endsequence
    AST_ADD_CARRY: assert property (add_w |=> st[0] == $past(sum[8]))
        else $error("carry wrong after add");
    AST_ADD_ZERO: assert property (add_w |=> st[2] == ($past(sum[7:0]) == 8'h00))
        else $error("zero wrong after add");
    AST_ADD_OVF: assert property (add_w |=> st[3] == $past(ovf))
        else $error("overflow wrong after add");
    AST_SUB_BORROW: assert property (sub_w |=> st[1:0] == $past(nobor))
        else $error("borrow flags wrong after sub");
    AST_CLR_STATUS: assert property (to_st(OP_CLR) |=> st == (($past(st) & 8'h0B) | 8'h04))
        else $error("status clear pattern wrong");
    AST_BSF_STATUS: assert property (to_st(OP_BSF) |=> st == $past(bsf_res))
        else $error("bit set on status wrong");
    AST_PTR0_STEP: assert property (ptr0_access && !exec_valid && !reg_wr
        |=> pointer0_out == 8'($past(pointer0_out) + $past(step0))) else $error("pointer0 step");
    AST_PTR1_STEP: assert property (ptr1_access && !exec_valid && !reg_wr
        |=> pointer1_out == 8'($past(pointer1_out) + $past(step1))) else $error("pointer1 step");
    AST_PROD_LOW: assert property (mul_rd |=> reg_rdata == $past(prod_lo, 2))
        else $error("product low byte wrong");
endmodule : alu_status_checker

bind alu_status_core alu_status_checker checker_i (.*);

// file: bench/testbench.sv
`timescale 1ns/100ps
// =====================================
// top of the status core bench
module testbench
    import alu_status_pkg::*;
;
    logic core_clk = 0, reset_n = 0, reg_wr = 0, reg_rd = 0;
    logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00;
    logic exec_valid, exec_to_file, ptr0_access, ptr1_access, result_valid_ff;
    alu_op_t exec_op;
    src_sel_t exec_src;
    logic [7:0] exec_imm, exec_file_data, exec_file_addr, reg_rdata, result_ff;
    logic [7:0] file_addr_ff, working_ff_out, alu_status_out, pointer0_out, pointer1_out;
    logic [2:0] exec_bit;
    int err_total = 0, total_checks = 0;
    alu_status_core DUT (.*);
    core_model core (.*);
    always #25 core_clk = ~core_clk;
    // =====================================
    // shared tasks
    task chk(logic [7:0] got, logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            err_total++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task wr(logic [7:0] a, logic [7:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1;
        @(posedge core_clk);
        reg_wr <= 0;
        // idle edge so a following write never re-raises the strobe at once
        @(posedge core_clk);
    endtask : wr
    task rd(logic [7:0] a, logic [7:0] exp);
        reg_addr <= a;
        reg_rd <= 1;
        @(posedge core_clk);
        reg_rd <= 0;
        @(negedge core_clk);
        chk(reg_rdata, exp);
        @(posedge core_clk);
    endtask : rd
    task complete_run;
        $display("checks=%0d errors=%0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : complete_run
    // =====================================
    // scenarios
    task t_reset;
        rd(ALU_STATUS_ADDR, ALU_STATUS_RESET);
        rd(8'h30, ZERO_BYTE);
    endtask : t_reset
    task t_add;
        wr(WORKING_ADDR, 8'h7F);
        core.issue(OP_ADD, SRC_FILE, 8'h01, 3'h0, 0, 8'h00);
        @(negedge core_clk);
        chk({7'h00, result_valid_ff}, ZERO_BYTE);
        chk(result_ff, 8'h80);
        @(posedge core_clk);
        rd(WORKING_ADDR, 8'h80);
        rd(ALU_STATUS_ADDR, 8'hFA);
        core.issue(OP_ADD, SRC_FILE, 8'h80, 3'h0, 0, 8'h00);
        rd(ALU_STATUS_ADDR, 8'hFD);
    endtask : t_add
    task t_sub;
        wr(WORKING_ADDR, 8'h05);
        core.issue(OP_SUB, SRC_IMM, 8'h03, 3'h0, 0, 8'h00);
        rd(WORKING_ADDR, 8'hFE);
        rd(ALU_STATUS_ADDR, 8'hF0);
        wr(WORKING_ADDR, 8'h05);
        core.issue(OP_SUB, SRC_IMM, 8'h05, 3'h0, 0, 8'h00);
        rd(ALU_STATUS_ADDR, 8'hF7);
    endtask : t_sub
    task t_status_dest;
        wr(ALU_STATUS_ADDR, 8'h5A);
        core.issue(OP_CLR, SRC_FILE, 8'h5A, 3'h0, 1, ALU_STATUS_ADDR);
        // result pulse stands for one cycle only; result and destination hold until the next instruction other than a multiply
        @(negedge core_clk);
        chk(result_ff, ZERO_BYTE);
        chk(file_addr_ff, ALU_STATUS_ADDR);
        chk({7'h00, result_valid_ff}, ONE_BYTE);
        @(posedge core_clk);
        rd(ALU_STATUS_ADDR, 8'h0E);
        core.issue(OP_BSF, SRC_FILE, 8'h0E, 3'h7, 1, ALU_STATUS_ADDR);
        rd(ALU_STATUS_ADDR, 8'h8E);
        wr(WORKING_ADDR, 8'h01);
        core.issue(OP_ADD, SRC_FILE, 8'h30, 3'h0, 1, ALU_STATUS_ADDR);
        rd(ALU_STATUS_ADDR, 8'h30);
    endtask : t_status_dest
    task t_mul;
        logic [15:0] p;
        p = 16'h00C3 * 16'h005B;
        wr(WORKING_ADDR, 8'hC3);
        core.issue(OP_MUL, SRC_FILE, 8'h5B, 3'h0, 0, 8'h00);
        rd(PRODUCT_LOW_ADDR, p[7:0]);
        rd(PRODUCT_HIGH_ADDR, p[15:8]);
        wr(PRODUCT_HIGH_ADDR, 8'hA5);
        reset_n <= 0;
        @(posedge core_clk);
        reset_n <= 1;
        rd(PRODUCT_HIGH_ADDR, 8'hA5);
        rd(PRODUCT_LOW_ADDR, p[7:0]);
    endtask : t_mul
    task t_ptr;
        logic [7:0] modes [3];
        logic [7:0] exp0 [3];
        logic [7:0] exp1 [3];
        modes = '{8'h40, 8'h10, 8'hB0};
        exp0 = '{8'h0F, 8'h10, 8'h10};
        exp1 = '{8'h11, 8'h10, 8'h10};
        wr(POINTER0_ADDR, 8'h10);
        wr(POINTER1_ADDR, 8'h10);
        for (int i = 0; i < 3; i++) begin
            wr(ALU_STATUS_ADDR, modes[i]);
            core.step(1, 1);
            rd(POINTER0_ADDR, exp0[i]);
            rd(POINTER1_ADDR, exp1[i]);
        end
    endtask : t_ptr
    task t_rot;
        wr(ALU_STATUS_ADDR, 8'hF1);
        core.issue(OP_RRC, SRC_FILE, 8'h02, 3'h0, 0, 8'h00);
        rd(WORKING_ADDR, 8'h81);
        rd(ALU_STATUS_ADDR, 8'hF0);
        core.issue(OP_RLC, SRC_FILE, 8'h80, 3'h0, 0, 8'h00);
        rd(WORKING_ADDR, 8'h00);
        rd(ALU_STATUS_ADDR, 8'hF1);
        core.issue(OP_AND, SRC_IMM, 8'hF0, 3'h0, 0, 8'h00);
        rd(ALU_STATUS_ADDR, 8'hF5);
        core.issue(OP_SWAP, SRC_FILE, 8'h3C, 3'h0, 0, 8'h00);
        rd(WORKING_ADDR, 8'hC3);
        rd(ALU_STATUS_ADDR, 8'hF5);
    endtask : t_rot
    // =====================================
    // main sequence and watchdog
    initial begin
        repeat (3) @(posedge core_clk);
        reset_n <= 1;
        t_reset();
        t_add();
        t_sub();
        t_status_dest();
        t_mul();
        t_ptr();
        t_rot();
        complete_run();
    end
    initial begin
        #200000;
        err_total++;
        complete_run();
    end
endmodule : testbench
